// ===== mss_params.svh
// offsets, reset values and sizes of the message send scoreboard
// assumes inclusion by bare name from every design file that needs them
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH

// ****************************************
// apb register map
// ****************************************
`define MSS_CTRL_OFF 12'h000
`define MSS_MBUSY_OFF 12'h004
`define MSS_GSEL_OFF 12'h008
`define MSS_GBUSY_OFF 12'h00C
`define MSS_STAT_OFF 12'h010
`define MSS_CTRL_TXEN_BIT 0
`define MSS_CTRL_RST 1'h1

// ****************************************
// sizes
// ****************************************
`define MSS_NUM_MREG 16
`define MSS_NUM_GREG 128
`define MSS_QDEPTH 4

`endif

// ===== mss_pkg.sv
// types shared by the message send scoreboard files
// assumes nothing of its surroundings
package mss_pkg;

    typedef enum logic [1:0] {
        MSS_IDLE = 2'b00,
        MSS_LOAD = 2'b01,
        MSS_CAPT = 2'b10,
        MSS_BEAT = 2'b11
    } mss_tx_e;

    typedef struct packed {
        logic [3:0] start;
        logic [3:0] mlen;
        logic [3:0] fid;
        logic [31:0] desc;
        logic [6:0] dst;
        logic [4:0] rlen;
        logic [15:0] channel_enable_mask;
        logic [2:0] tid;
        logic [3:0] unit;
    } mss_msg_s;

endpackage

// ===== mss_mreg_mem.sv
// message operand register storage: 16 x 256 bits, word write mask
// assumes one write and one read per cycle; read data one cycle later
`timescale 1ns/1ns
module mss_mreg_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [15:0] wr_wmask,
    input wire logic [255:0] wr_data,
    input wire logic rd_en,
    input wire logic [3:0] rd_idx,
    output logic [255:0] rd_data_ff
);
    logic [255:0] mem [0:15];

    // words of 16 bits are written alone
    always_ff @(posedge clk) begin
        for (int w = 0; w < 16; w++) begin
            if (wr_en && wr_wmask[w]) begin
                mem[wr_idx][w*16 +: 16] <= wr_data[w*16 +: 16];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 256'h0;
        end else if (rd_en) begin
            rd_data_ff <= mem[rd_idx];
        end
    end
endmodule // mss_mreg_mem

// ===== mss_sendq.sv
// in-order queue of accepted send descriptors
// assumes the consumer pops only while pop_valid_ff is high
`timescale 1ns/1ns
`include "mss_params.svh"
module mss_sendq (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push_valid,
    input mss_pkg::mss_msg_s push_data,
    output logic push_ready,
    output logic pop_valid_ff,
    input wire logic pop_ready,
    output mss_pkg::mss_msg_s pop_data,
    output logic [2:0] level_ff
);
    mss_pkg::mss_msg_s buf_ff [0:`MSS_QDEPTH-1];
    logic [1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [2:0] nxt_level;
    logic push, pop;

    assign push_ready = (level_ff != 3'h4);
    assign push = push_valid && push_ready;
    assign pop = pop_valid_ff && pop_ready;
    assign pop_data = buf_ff[rp_ff];

    always_comb begin
        nxt_wp = wp_ff + 2'(push);
        nxt_rp = rp_ff + 2'(pop);
        nxt_level = level_ff + 3'(push) - 3'(pop);
        if (flush) begin
            nxt_wp = 2'h0;
            nxt_rp = 2'h0;
            nxt_level = 3'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= 2'h0;
            rp_ff <= 2'h0;
            level_ff <= 3'h0;
            pop_valid_ff <= 1'b0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            level_ff <= nxt_level;
            pop_valid_ff <= (nxt_level != 3'h0);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            buf_ff[wp_ff] <= push_data;
        end
    end
endmodule // mss_sendq

// ===== mss_scoreboard.sv
// per-thread message staging, send queue and in-flight scoreboard
// assumes instruction side and fabric side are synchronous to pclk
`timescale 1ns/1ns
`include "mss_params.svh"

module mss_scoreboard (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_ff,
    output logic pready_ff,
    output logic pslverr_ff,
    input wire logic thread_dispatch,
    input wire logic mreg_wr_req,
    input wire logic [3:0] mreg_wr_idx,
    input wire logic [15:0] mreg_wr_wmask,
    input wire logic [255:0] mreg_wr_data,
    output logic mreg_wr_ack_ff,
    output logic mreg_wr_stall_ff,
    input wire logic greg_rd_req,
    input wire logic [6:0] greg_rd_idx,
    output logic greg_rd_stall_ff,
    input wire logic send_req,
    input wire logic [3:0] send_start,
    input wire logic [3:0] send_mlen,
    input wire logic [3:0] send_fid,
    input wire logic [31:0] send_desc,
    input wire logic send_dst_null,
    input wire logic [6:0] send_dst,
    input wire logic [4:0] send_rlen,
    input wire logic [15:0] send_channel_enable_mask,
    input wire logic [2:0] send_tid,
    input wire logic [3:0] send_unit,
    input wire logic send_move_en,
    input wire logic [255:0] send_move_data,
    output logic send_ack_ff,
    output logic send_stall_ff,
    output logic msg_valid_ff,
    input wire logic msg_ready,
    output logic [255:0] msg_data_ff,
    output logic msg_last_ff,
    output mss_pkg::mss_msg_s msg_side_ff,
    input wire logic wb_valid,
    input wire logic [6:0] wb_idx,
    input wire logic [255:0] wb_data,
    output logic greg_wr_en_ff,
    output logic [6:0] greg_wr_idx_ff,
    output logic [255:0] greg_wr_data_ff
);
    // ****************************************
    // helpers
    // ****************************************
    // registers past the last index are dropped, never wrapped
    function automatic logic [15:0] mss_mmask(logic [3:0] s, logic [3:0] n);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            m[i] = (i >= int'(s)) && (i < int'(s) + int'(n));
        end
        return m;
    endfunction

    function automatic logic [127:0] mss_gmask(logic [6:0] s, logic [4:0] n);
        logic [127:0] m;
        m = 128'h0;
        for (int i = 0; i < 128; i++) begin
            m[i] = (i >= int'(s)) && (i < int'(s) + int'(n));
        end
        return m;
    endfunction

    function automatic logic mss_hit(logic [11:0] a);
        return (a == `MSS_CTRL_OFF) || (a == `MSS_MBUSY_OFF) || (a == `MSS_GSEL_OFF)
            || (a == `MSS_GBUSY_OFF) || (a == `MSS_STAT_OFF);
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    logic [15:0] mbusy_ff, nxt_mbusy;
    logic [127:0] gbusy_ff, nxt_gbusy;
    logic ctrl_txen_ff, nxt_txen;
    logic [1:0] gsel_ff, nxt_gsel;
    logic [15:0] sent_ff, nxt_sent;
    mss_pkg::mss_tx_e st_ff, nxt_st;
    logic [3:0] beat_ff, nxt_beat;
    mss_pkg::mss_msg_s nxt_side, q_in, q_out;
    logic nxt_valid, nxt_last, q_ready, q_valid, pop, done;
    logic [255:0] nxt_mdata;
    logic [2:0] q_level;
    logic wr_acc, send_acc, mem_we;
    logic [15:0] pay_mask;
    logic [255:0] rd_data;
    logic nxt_pready, nxt_pslverr, apb_wr;
    logic [31:0] nxt_prdata;

    // ****************************************
    // acceptance of writes and sends
    // ****************************************
    assign pay_mask = mss_mmask(send_start, send_mlen);
    assign wr_acc = mreg_wr_req && !mreg_wr_ack_ff && !mbusy_ff[mreg_wr_idx]
        && !thread_dispatch;
    // a pending operand write holds the send back so it lands first
    assign send_acc = send_req && !send_ack_ff && q_ready && !mreg_wr_req
        && !thread_dispatch && ((mbusy_ff & pay_mask) == 16'h0000);
    assign mem_we = wr_acc || (send_acc && send_move_en);

    always_comb begin
        q_in = '0;
        q_in.start = send_start;
        q_in.mlen = send_mlen;
        q_in.fid = send_fid;
        q_in.desc = send_desc;
        q_in.dst = send_dst;
        // null destination forces no writeback whatever the function control says
        q_in.rlen = send_dst_null ? 5'h00 : send_rlen;
        q_in.channel_enable_mask = send_channel_enable_mask;
        q_in.tid = send_tid;
        q_in.unit = send_unit;
    end

    // only a write port faces instructions: no operand read reaches them
    mss_mreg_mem u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(mem_we),
        .wr_idx(send_acc ? send_start : mreg_wr_idx),
        .wr_wmask(send_acc ? 16'hFFFF : mreg_wr_wmask),
        .wr_data(send_acc ? send_move_data : mreg_wr_data),
        .rd_en(st_ff == mss_pkg::MSS_LOAD),
        .rd_idx(msg_side_ff.start + beat_ff),
        .rd_data_ff(rd_data)
    );

    mss_sendq u_q (
        .clk(pclk),
        .rst_n(presetn),
        .flush(thread_dispatch),
        .push_valid(send_acc),
        .push_data(q_in),
        .push_ready(q_ready),
        .pop_valid_ff(q_valid),
        .pop_ready(pop),
        .pop_data(q_out),
        .level_ff(q_level)
    );

    // ****************************************
    // transmit engine
    // ****************************************
    assign pop = (st_ff == mss_pkg::MSS_IDLE) && q_valid && ctrl_txen_ff;
    assign done = (st_ff == mss_pkg::MSS_BEAT) && msg_ready && msg_last_ff;

    always_comb begin
        nxt_st = st_ff;
        nxt_beat = beat_ff;
        nxt_side = msg_side_ff;
        nxt_valid = msg_valid_ff;
        nxt_last = msg_last_ff;
        nxt_mdata = msg_data_ff;
        nxt_sent = sent_ff + 16'(done);
        case (st_ff)
            mss_pkg::MSS_IDLE: begin
                if (pop) begin
                    nxt_side = q_out;
                    nxt_beat = 4'h0;
                    nxt_st = mss_pkg::MSS_LOAD;
                end
            end
            mss_pkg::MSS_LOAD: begin
                nxt_st = mss_pkg::MSS_CAPT;
            end
            mss_pkg::MSS_CAPT: begin
                // a read only copies out; the stored payload stays for reuse
                nxt_mdata = rd_data;
                nxt_valid = 1'b1;
                nxt_last = (beat_ff + 4'h1 >= msg_side_ff.mlen);
                nxt_st = mss_pkg::MSS_BEAT;
            end
            mss_pkg::MSS_BEAT: begin
                if (msg_ready) begin
                    nxt_valid = 1'b0;
                    nxt_last = 1'b0;
                    nxt_beat = beat_ff + 4'h1;
                    nxt_st = msg_last_ff ? mss_pkg::MSS_IDLE : mss_pkg::MSS_LOAD;
                end
            end
            default: begin
                nxt_st = mss_pkg::MSS_IDLE;
            end
        endcase
        if (thread_dispatch) begin
            nxt_st = mss_pkg::MSS_IDLE;
            nxt_valid = 1'b0;
            nxt_last = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= mss_pkg::MSS_IDLE;
            beat_ff <= 4'h0;
            msg_side_ff <= '0;
            msg_valid_ff <= 1'b0;
            msg_last_ff <= 1'b0;
            msg_data_ff <= 256'h0;
            sent_ff <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
            beat_ff <= nxt_beat;
            msg_side_ff <= nxt_side;
            msg_valid_ff <= nxt_valid;
            msg_last_ff <= nxt_last;
            msg_data_ff <= nxt_mdata;
            sent_ff <= nxt_sent;
        end
    end

    // ****************************************
    // in-flight flags and stalls
    // ****************************************
    always_comb begin
        nxt_mbusy = mbusy_ff;
        nxt_gbusy = gbusy_ff;
        if (done) begin
            nxt_mbusy = nxt_mbusy & ~mss_mmask(msg_side_ff.start, msg_side_ff.mlen);
        end
        if (wb_valid) begin
            nxt_gbusy[wb_idx] = 1'b0;
        end
        // sets follow the done and writeback clears so a set wins over those; the dispatch clear comes last and wins over a set
        if (send_acc) begin
            nxt_mbusy = nxt_mbusy | pay_mask;
            nxt_gbusy = nxt_gbusy | mss_gmask(q_in.dst, q_in.rlen);
        end
        if (thread_dispatch) begin
            nxt_mbusy = 16'h0000;
            nxt_gbusy = 128'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mbusy_ff <= 16'h0000;
            gbusy_ff <= 128'h0;
            mreg_wr_ack_ff <= 1'b0;
            mreg_wr_stall_ff <= 1'b0;
            greg_rd_stall_ff <= 1'b0;
            send_ack_ff <= 1'b0;
            send_stall_ff <= 1'b0;
            greg_wr_en_ff <= 1'b0;
            greg_wr_idx_ff <= 7'h00;
            greg_wr_data_ff <= 256'h0;
        end else begin
            mbusy_ff <= nxt_mbusy;
            gbusy_ff <= nxt_gbusy;
            mreg_wr_ack_ff <= wr_acc;
            mreg_wr_stall_ff <= mreg_wr_req && !wr_acc && !mreg_wr_ack_ff;
            greg_rd_stall_ff <= greg_rd_req && nxt_gbusy[greg_rd_idx];
            send_ack_ff <= send_acc;
            send_stall_ff <= send_req && !send_acc && !send_ack_ff;
            greg_wr_en_ff <= wb_valid;
            greg_wr_idx_ff <= wb_idx;
            greg_wr_data_ff <= wb_data;
        end
    end

    // ****************************************
    // apb slave, one access cycle, error on unmapped
    // ****************************************
    assign apb_wr = psel && penable && pready_ff && pwrite && !pslverr_ff;

    always_comb begin
        nxt_pready = psel && !penable;
        nxt_pslverr = psel && !penable && !mss_hit(paddr);
        nxt_prdata = 32'h0000_0000;
        nxt_txen = ctrl_txen_ff;
        nxt_gsel = gsel_ff;
        case (paddr)
            `MSS_CTRL_OFF: nxt_prdata = {31'h0, ctrl_txen_ff};
            `MSS_MBUSY_OFF: nxt_prdata = {16'h0000, mbusy_ff};
            `MSS_GSEL_OFF: nxt_prdata = {30'h0, gsel_ff};
            `MSS_GBUSY_OFF: nxt_prdata = gbusy_ff[gsel_ff*32 +: 32];
            `MSS_STAT_OFF: nxt_prdata = {sent_ff, 11'h000, q_level, st_ff};
            default: nxt_prdata = 32'h0000_0000;
        endcase
        if (!(psel && !penable)) begin
            nxt_prdata = prdata_ff;
        end
        if (apb_wr && paddr == `MSS_CTRL_OFF) begin
            nxt_txen = pwdata[`MSS_CTRL_TXEN_BIT];
        end
        if (apb_wr && paddr == `MSS_GSEL_OFF) begin
            nxt_gsel = pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            ctrl_txen_ff <= `MSS_CTRL_RST;
            gsel_ff <= 2'h0;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            ctrl_txen_ff <= nxt_txen;
            gsel_ff <= nxt_gsel;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_send_marks: assert property (send_acc |=> ((mbusy_ff & $past(pay_mask)) == $past(pay_mask)))
        else $error("payload flags not set after send");
    chk_write_blocked: assert property (wr_acc |-> !mbusy_ff[mreg_wr_idx])
        else $error("write accepted to in-flight register");
    chk_stall_shown: assert property (mreg_wr_req && mbusy_ff[mreg_wr_idx] && !mreg_wr_ack_ff
        |=> mreg_wr_stall_ff && !mreg_wr_ack_ff)
        else $error("blocked write not stalled");
    chk_flags_held: assert property (msg_valid_ff |-> mbusy_ff[msg_side_ff.start])
        else $error("lead flag cleared before transmission");
    chk_flags_clear: assert property (done && !send_acc && !thread_dispatch |=> ((mbusy_ff
        & mss_mmask($past(msg_side_ff.start), $past(msg_side_ff.mlen))) == 16'h0000))
        else $error("payload flags not cleared after last beat");
    chk_no_wr_race: assert property (send_acc |-> !wr_acc)
        else $error("send taken beside an operand write");
    chk_beat_hold: assert property (msg_valid_ff && !msg_ready && !thread_dispatch
        |=> msg_valid_ff && $stable(msg_data_ff) && $stable(msg_side_ff))
        else $error("beat changed while stalled");
    chk_grf_mark: assert property (send_acc && !send_dst_null && send_rlen != 5'h00
        && !thread_dispatch |=> gbusy_ff[$past(send_dst)])
        else $error("writeback register not marked");
    chk_wb_clear: assert property (wb_valid && !send_acc && !thread_dispatch
        |=> greg_wr_en_ff && !gbusy_ff[greg_wr_idx_ff])
        else $error("returned register still in flight");
    chk_dispatch_clr: assert property (thread_dispatch |=> mbusy_ff == 16'h0000
        && gbusy_ff == 128'h0 && !msg_valid_ff)
        else $error("flags left after dispatch");
    chk_apb_answer: assert property (psel && !penable |=> pready_ff)
        else $error("apb access phase not answered");

    cov_send: cover property (send_acc ##[1:40] done);
    cov_write_stall: cover property (mreg_wr_stall_ff ##[1:60] mreg_wr_ack_ff);
    cov_read_stall: cover property (greg_rd_stall_ff ##1 greg_wr_en_ff);
    cov_two_queued: cover property (q_level == 3'h2);
endmodule // mss_scoreboard

// ===== mss_fabric_model.sv
// shared function side of the message fabric: takes beats, returns writebacks
// assumes the scoreboard's msg_* handshake and one wb register per pulse
`timescale 1ns/1ns
module mss_fabric_model #(
    parameter int READY_WAIT = 2
) (
    input wire logic pclk,
    input wire logic msg_valid_ff,
    input wire logic [255:0] msg_data_ff,
    input wire logic msg_last_ff,
    input mss_pkg::mss_msg_s msg_side_ff,
    output logic msg_ready,
    output logic wb_valid,
    output logic [6:0] wb_idx,
    output logic [255:0] wb_data
);
    logic [255:0] beats [$];
    logic lasts [$];
    mss_pkg::mss_msg_s side;

    // ****************************************
    // beat intake and reply
    // ****************************************
    // slow on purpose: ready comes READY_WAIT+1 edges after valid
    initial begin
        msg_ready = 1'b0;
        wb_valid = 1'b0;
        wb_idx = 7'h00;
        wb_data = '0;
        forever begin
            @(posedge pclk);
            if (msg_valid_ff === 1'b1) begin
                repeat (READY_WAIT) @(posedge pclk);
                msg_ready <= 1'b1;
                @(posedge pclk);
                beats.push_back(msg_data_ff);
                lasts.push_back(msg_last_ff);
                side = msg_side_ff;
                msg_ready <= 1'b0;
                // the next message may already show its sideband: reply from the copy
                if (msg_last_ff === 1'b1 && side.rlen != 5'h00) begin
                    repeat (3) @(posedge pclk);
                    for (int k = 0; k < int'(side.rlen); k++) begin
                        wb_valid <= 1'b1;
                        wb_idx <= side.dst + 7'(k);
                        wb_data <= {8{32'hD00D_0000 | k}};
                        @(posedge pclk);
                    end
                    wb_valid <= 1'b0;
                    // released data is inverted once so nothing stale reads as valid
                    wb_data <= ~wb_data;
                end
            end
        end
    end
endmodule // mss_fabric_model

// ===== tb_top.sv
// self-checking bench for the message send scoreboard
// assumes one 125 MHz clock and the fabric model at the message port
`timescale 1ns/1ns
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, thread_dispatch;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_ff, r;
    logic e, mreg_wr_req, mreg_wr_ack_ff, mreg_wr_stall_ff, greg_rd_req, greg_rd_stall_ff;
    logic [3:0] mreg_wr_idx, send_start, send_mlen, send_fid, send_unit;
    logic [15:0] mreg_wr_wmask, send_channel_enable_mask;
    logic [255:0] mreg_wr_data, send_move_data, msg_data_ff, wb_data, greg_wr_data_ff;
    logic [6:0] greg_rd_idx, send_dst, wb_idx, greg_wr_idx_ff;
    logic send_req, send_dst_null, send_move_en, send_ack_ff, send_stall_ff, msg_valid_ff;
    logic msg_ready, msg_last_ff, wb_valid, greg_wr_en_ff;
    logic [31:0] send_desc;
    logic [4:0] send_rlen;
    logic [2:0] send_tid;
    mss_pkg::mss_msg_s msg_side_ff;
    int num_errors = 0, n_checks = 0, n_wb = 0;
    localparam logic [255:0] MOVE = {8{32'h5A5A_0003}};
    localparam logic [255:0] NEWV = {8{32'h1234_5678}};

    mss_scoreboard DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_ff, .pready_ff, .pslverr_ff, .thread_dispatch, .mreg_wr_req, .mreg_wr_idx,
        .mreg_wr_wmask, .mreg_wr_data, .mreg_wr_ack_ff, .mreg_wr_stall_ff, .greg_rd_req,
        .greg_rd_idx, .greg_rd_stall_ff, .send_req, .send_start, .send_mlen, .send_fid,
        .send_desc, .send_dst_null, .send_dst, .send_rlen, .send_channel_enable_mask, .send_tid,
        .send_unit, .send_move_en, .send_move_data, .send_ack_ff, .send_stall_ff,
        .msg_valid_ff, .msg_ready, .msg_data_ff, .msg_last_ff, .msg_side_ff, .wb_valid,
        .wb_idx, .wb_data, .greg_wr_en_ff, .greg_wr_idx_ff, .greg_wr_data_ff);
    mss_fabric_model FAB (.pclk, .msg_valid_ff, .msg_data_ff, .msg_last_ff,
        .msg_side_ff, .msg_ready, .wb_valid, .wb_idx, .wb_data);

    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [255:0] pat(input logic [3:0] i);
        return {8{16'hCAFE, 12'h000, i}};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_ff !== 1'b1);
        r = prdata_ff;
        e = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mwr(input logic [3:0] i, input logic [255:0] d);
        @(posedge pclk);
        mreg_wr_req <= 1'b1;
        mreg_wr_idx <= i;
        mreg_wr_data <= d;
        do @(posedge pclk); while (mreg_wr_ack_ff !== 1'b1);
        mreg_wr_req <= 1'b0;
    endtask
    task automatic snd(input logic [3:0] st, ml, fd, input logic nul, input logic [6:0] ds,
                       input logic [4:0] rl, input logic mv);
        @(posedge pclk);
        {send_req, send_start, send_mlen, send_fid} <= {1'b1, st, ml, fd};
        {send_dst_null, send_dst, send_rlen, send_move_en} <= {nul, ds, rl, mv};
        do @(posedge pclk); while (send_ack_ff !== 1'b1);
        send_req <= 1'b0;
    endtask
    task automatic wt(input int k);
        while (FAB.beats.size() < k) @(posedge pclk);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog and tests
    // ****************************************
    initial begin pclk = 1'b0; forever #4 pclk = ~pclk; end
    // the only replying message returns to r10 and r11, in order
    always @(posedge pclk) begin
        if (greg_wr_en_ff === 1'b1) begin
            chk("wb idx", greg_wr_idx_ff, 7'h0A + 7'(n_wb));
            chk("wb data", greg_wr_data_ff, {8{32'hD00D_0000 | n_wb}});
            n_wb++;
        end
    end
    initial begin repeat (20000) @(posedge pclk); num_errors++; complete_run; end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, thread_dispatch} = '0;
        {mreg_wr_req, mreg_wr_idx, mreg_wr_data, greg_rd_req, greg_rd_idx} = '0;
        {send_req, send_start, send_mlen, send_fid, send_dst_null, send_dst} = '0;
        {send_rlen, send_move_en} = '0;
        mreg_wr_wmask = 16'hFFFF;
        {send_desc, send_channel_enable_mask, send_tid, send_unit} = {32'h0211_0001, 16'hBEEF, 3'h5, 4'h9};
        send_move_data = MOVE;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 0); chk("ctrl", r, 1);
        apb(0, 12'h004, 0); chk("mbusy", r, 0);
        apb(1, 12'h020, 32'hFFFF_FFFF); chk("slverr", e, 1);
        apb(1, 12'h000, 0);
        $display("test reset done");
        for (int i = 1; i < 6; i++) mwr(4'(i), pat(4'(i)));
        snd(1, 1, 2, 0, 0, 0, 0);
        snd(3, 3, 5, 0, 10, 2, 1);
        apb(0, 12'h004, 0); chk("mbusy", r, 32'h0000_003A);
        apb(1, 12'h008, 0);
        apb(0, 12'h00C, 0); chk("gbusy", r, 32'h0000_0C00);
        greg_rd_idx <= 7'h0B;
        greg_rd_req <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("rd stall", greg_rd_stall_ff, 1);
        greg_rd_req <= 1'b0;
        fork
            mwr(4, NEWV);
            begin
                repeat (4) @(posedge pclk);
                chk("wr stall", mreg_wr_stall_ff, 1);
                apb(1, 12'h000, 1);
            end
        join
        wt(4);
        chk("beat0", FAB.beats[0], pat(1));
        chk("beat1", FAB.beats[1], MOVE);
        chk("beat2", FAB.beats[2], pat(4));
        chk("beat3", FAB.beats[3], pat(5));
        chk("last", {FAB.lasts[0], FAB.lasts[1], FAB.lasts[2], FAB.lasts[3]}, 4'h9);
        chk("channel_enable_mask", FAB.side.channel_enable_mask, 16'hBEEF);
        chk("side", {FAB.side.fid, FAB.side.dst, FAB.side.unit}, {4'h5, 7'h0A, 4'h9});
        repeat (30) @(posedge pclk);
        apb(0, 12'h00C, 0); chk("gbusy", r, 0);
        apb(0, 12'h004, 0); chk("mbusy", r, 0);
        apb(0, 12'h010, 0); chk("sent", r[31:16], 16'h0002);
        chk("wb count", n_wb, 2);
        $display("test queue done");
        snd(3, 3, 6, 1, 0, 0, 0);
        wt(7);
        chk("keep3", FAB.beats[4], MOVE);
        chk("keep4", FAB.beats[5], NEWV);
        repeat (20) @(posedge pclk);
        chk("no reply", n_wb, 2);
        $display("test resend done");
        apb(1, 12'h000, 0);
        apb(1, 12'h008, 1);
        snd(6, 2, 1, 0, 40, 1, 0);
        apb(0, 12'h004, 0); chk("mbusy", r, 32'h0000_00C0);
        apb(0, 12'h00C, 0); chk("gbusy", r, 32'h0000_0100);
        // an overlapping send waits; dispatch clears the flags and lets it in
        fork
            snd(7, 1, 1, 1, 0, 0, 0);
            begin
                repeat (3) @(posedge pclk);
                chk("send stall", send_stall_ff, 1);
                thread_dispatch <= 1'b1;
                @(posedge pclk) thread_dispatch <= 1'b0;
            end
        join
        apb(0, 12'h004, 0); chk("mbusy", r, 32'h0000_0080);
        apb(0, 12'h00C, 0); chk("gbusy", r, 0);
        $display("test dispatch done");
        complete_run;
    end
endmodule // tb_top
